// ### logic/dsp_int_logic_multiply_unit.v
// DSP integer increment/decrement, bitwise logic and fixed-point multiply unit
//
// Summary of operation
// RULE_01 - Increment and decrement work on 24 bits
// RULE_02 - Guardless sources are sign-extended into guard
// RULE_03 - Guardless destination gets upper word only
// RULE_04 - Integer ops ignore and clear lower word
// RULE_05 - Only increment/decrement, operand fixed plus/minus one
// RULE_06 - Loaded word goes into upper word
// RULE_07 - Integer flags exclude lower words
// RULE_08 - Conditional ops keep flags; unconditional update
// RULE_09 - Saturation bit applies to increment/decrement
// RULE_10 - Bitwise sources and destination chosen independently
// RULE_11 - Bitwise uses upper word; rest cleared
// RULE_12 - Bitwise carry/overflow/greater modes clear flag
// RULE_13 - Bitwise negative mode takes result bit 31
// RULE_14 - Bitwise zero mode flags zero result
// RULE_15 - N, Z, V, greater flags follow modes
// RULE_16 - Multiply uses upper words of sources
// RULE_17 - Multiply 32-bit; guard copies bit 31 (code clears the guard for the unsaturated 8000 times 8000 result)
// RULE_18 - Multiply result MSB-aligned, LSB zero
// RULE_19 - Multiply unconditional, flags untouched
// RULE_20 - 8000 times 8000 overflows or saturates
// RULE_21 - Multiply operand register sets restricted
// RULE_22 - All ops complete in DSP stage
// RULE_23 - Carry mode shows carry out excluding guard
// RULE_24 - Overflow mode ignores destination guard bits
// RULE_25 - Source sets restricted; any destination
// RULE_26 - Reserved condition selects clear the flag
`timescale 1ns/1ns
`include "dsp_int_logic_multiply_unit_defs.vh"

module dsp_int_logic_multiply_unit (
  input wire clk,
  input wire rst,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire op_conditional,
  input wire op_use_second,
  input wire [1:0] first_source_select,
  input wire [1:0] second_source_select,
  input wire [2:0] result_target_select,
  input wire [1:0] mul_first_operand,
  input wire [1:0] mul_second_operand,
  input wire [1:0] mul_result_target,
  input wire load_valid,
  input wire [2:0] load_target,
  input wire [15:0] load_word,
  input wire [3:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_write,
  input wire bus_read,
  output reg [31:0] bus_rdata,
  output wire [2:0] cond_select,
  output wire saturate_enable,
  output wire selectable_condition_flag,
  output wire negative_flag,
  output wire zero_flag,
  output wire overflow_flag,
  output wire greater_than_flag,
  output reg op_illegal_ff
);

  reg [39:0] dsp_reg_ff [0:7];
  reg [2:0] cs_ff;
  reg sat_ff;
  reg sel_flag_ff;
  reg n_ff;
  reg z_ff;
  reg v_ff;
  reg greater_ff;
  reg [2:0] dst;
  reg [39:0] result;
  reg wr_en;
  reg flags_en;
  reg illegal;
  reg nxt_sel_flag;
  reg nxt_n;
  reg nxt_z;
  reg nxt_v;
  reg nxt_greater;
  reg [39:0] src_a;
  reg [23:0] ext;
  reg [24:0] sum;
  reg [15:0] lw;
  reg [31:0] prod;
  reg signed [31:0] sprod;
  integer i;

  assign cond_select = cs_ff;
  assign saturate_enable = sat_ff;
  assign selectable_condition_flag = sel_flag_ff;
  assign negative_flag = n_ff;
  assign zero_flag = z_ff;
  assign overflow_flag = v_ff;
  assign greater_than_flag = greater_ff;

  // Register has guard bits only for the accumulators
  function has_guard;
    input [2:0] idx;
    begin
      has_guard = (idx == `REG_ACC0) || (idx == `REG_ACC1);
    end
  endfunction

  // First-source selector maps onto the accumulators and x inputs
  function [2:0] map_first;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: map_first = `REG_ACC0;
        2'h1: map_first = `REG_ACC1;
        2'h2: map_first = `REG_XIN0;
        default: map_first = `REG_XIN1;
      endcase
    end
  endfunction

  // Second-source selector maps onto the y inputs and multiply registers
  function [2:0] map_second;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: map_second = `REG_YIN0;
        2'h1: map_second = `REG_YIN1;
        2'h2: map_second = `REG_MUL0;
        default: map_second = `REG_MUL1;
      endcase
    end
  endfunction

  // Guard bits of a guardless register copy the sign
  function [39:0] read_ext;
    input [2:0] idx;
    input [39:0] val;
    begin
      if (has_guard(idx)) begin
        read_ext = val;
      end else begin
        read_ext = {{8{val[`UPPER_MSB]}}, val[31:0]}; // RULE_02
      end
    end
  endfunction

  // Multiply first operand: ACC1, XIN0, XIN1, YIN0
  function [2:0] map_mul_first;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: map_mul_first = `REG_ACC1;
        2'h1: map_mul_first = `REG_XIN0;
        2'h2: map_mul_first = `REG_XIN1;
        default: map_mul_first = `REG_YIN0;
      endcase
    end
  endfunction

  // Multiply second operand: ACC1, XIN0, YIN0, YIN1
  function [2:0] map_mul_second;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: map_mul_second = `REG_ACC1;
        2'h1: map_mul_second = `REG_XIN0;
        2'h2: map_mul_second = `REG_YIN0;
        default: map_mul_second = `REG_YIN1;
      endcase
    end
  endfunction

  // Multiply destination: ACC0, ACC1, MUL0, MUL1
  function [2:0] map_mul_target;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: map_mul_target = `REG_ACC0;
        2'h1: map_mul_target = `REG_ACC1;
        2'h2: map_mul_target = `REG_MUL0;
        default: map_mul_target = `REG_MUL1;
      endcase
    end
  endfunction

  // Datapath: one operation evaluated and committed per cycle
  always @* begin
    dst = result_target_select; // RULE_25
    result = 40'h0;
    wr_en = 1'b0;
    flags_en = 1'b0;
    illegal = 1'b0;
    nxt_sel_flag = sel_flag_ff;
    nxt_n = n_ff;
    nxt_z = z_ff;
    nxt_v = v_ff;
    nxt_greater = greater_ff;
    src_a = 40'h0;
    ext = 24'h0;
    sum = 25'h0;
    lw = 16'h0;
    prod = 32'h0;
    sprod = 32'sh0;
    if (op_valid) begin
      case (op_code)
        `OP_INC, `OP_DEC: begin
          // RULE_05 RULE_25
          if (op_use_second) begin
            src_a = read_ext(map_second(second_source_select),
                             dsp_reg_ff[map_second(second_source_select)]);
          end else begin
            src_a = read_ext(map_first(first_source_select),
                             dsp_reg_ff[map_first(first_source_select)]);
          end
          ext = src_a[`GUARD_MSB:`UPPER_LSB]; // RULE_01 RULE_04
          if (op_code == `OP_INC) begin
            sum = {1'b0, ext} + 25'h1;
          end else begin
            sum = {1'b0, ext} + 25'h1FFFFFF;
          end
          lw = sum[15:0];
          // RULE_24 RULE_09
          if (sat_ff && (sum[23:15] != {9{sum[23]}})) begin
            lw = sum[23] ? `INT_SAT_MIN : `INT_SAT_MAX;
            result = {{8{lw[15]}}, lw, 16'h0};
          end else begin
            result = {sum[23:0], 16'h0}; // RULE_04
          end
          if (!has_guard(dst)) begin
            result = {{8{result[`UPPER_MSB]}}, result[31:0]}; // RULE_03
          end
          wr_en = 1'b1;
          flags_en = !op_conditional; // RULE_08
          nxt_n = sum[23]; // RULE_07 RULE_15
          nxt_z = (sum[23:0] == 24'h0);
          nxt_v = (sum[23:15] != {9{sum[23]}}); // RULE_24
          nxt_greater = !nxt_n && !nxt_z;
          case (cs_ff)
            `CS_CARRY: nxt_sel_flag = (op_code == `OP_INC) ? (ext[15:0] == 16'hFFFF)
                                                           : (ext[15:0] == 16'h0); // RULE_23
            `CS_NEG: nxt_sel_flag = nxt_n;
            `CS_ZERO: nxt_sel_flag = nxt_z;
            `CS_OVF: nxt_sel_flag = nxt_v;
            `CS_GREATER: nxt_sel_flag = nxt_greater;
            `CS_GE: nxt_sel_flag = !nxt_n;
            default: nxt_sel_flag = 1'b0; // RULE_26
          endcase
        end
        `OP_AND, `OP_OR, `OP_XOR: begin
          // RULE_10 RULE_11
          if (op_code == `OP_AND) begin
            lw = dsp_reg_ff[map_first(first_source_select)][31:16] &
                 dsp_reg_ff[map_second(second_source_select)][31:16];
          end else if (op_code == `OP_OR) begin
            lw = dsp_reg_ff[map_first(first_source_select)][31:16] |
                 dsp_reg_ff[map_second(second_source_select)][31:16];
          end else begin
            lw = dsp_reg_ff[map_first(first_source_select)][31:16] ^
                 dsp_reg_ff[map_second(second_source_select)][31:16];
          end
          result = {8'h0, lw, 16'h0}; // RULE_11
          wr_en = 1'b1;
          flags_en = !op_conditional; // RULE_08
          nxt_n = lw[15]; // RULE_13 RULE_15
          nxt_z = (lw == 16'h0); // RULE_14
          nxt_v = 1'b0;
          nxt_greater = 1'b0;
          case (cs_ff)
            `CS_NEG: nxt_sel_flag = nxt_n; // RULE_13
            `CS_ZERO: nxt_sel_flag = nxt_z; // RULE_14
            default: nxt_sel_flag = 1'b0; // RULE_12 RULE_26
          endcase
        end
        `OP_MUL: begin
          // RULE_16 RULE_21
          dst = map_mul_target(mul_result_target);
          sprod = $signed(dsp_reg_ff[map_mul_first(mul_first_operand)][31:16]) *
                  $signed(dsp_reg_ff[map_mul_second(mul_second_operand)][31:16]);
          prod = {sprod[30:0], 1'b0}; // RULE_18
          if (prod == `MUL_OVF_RESULT) begin
            prod = sat_ff ? `MUL_SAT_RESULT : `MUL_OVF_RESULT; // RULE_20
            result = {8'h0, prod}; // RULE_20
          end else begin
            result = {{8{prod[31]}}, prod}; // RULE_17
          end
          wr_en = 1'b1; // RULE_19
          flags_en = 1'b0; // RULE_19
        end
        `OP_NONE: begin
          wr_en = 1'b0;
        end
        default: illegal = 1'b1;
      endcase
    end
  end

  // Commit result, flags and loads at the end of the DSP stage
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        dsp_reg_ff[i] <= 40'h0;
      end
      cs_ff <= `CS_CARRY;
      sat_ff <= 1'b0;
      sel_flag_ff <= 1'b0;
      n_ff <= 1'b0;
      z_ff <= 1'b0;
      v_ff <= 1'b0;
      greater_ff <= 1'b0;
      op_illegal_ff <= 1'b0;
      bus_rdata <= 32'h0;
    end else begin
      op_illegal_ff <= illegal;
      if (wr_en) begin
        dsp_reg_ff[dst] <= result; // RULE_22
      end
      if (load_valid && !(wr_en && dst == load_target)) begin
        dsp_reg_ff[load_target] <= {{8{load_word[15]}}, load_word, 16'h0}; // RULE_06
      end else if (load_valid) begin
        dsp_reg_ff[load_target] <= {{8{load_word[15]}}, load_word, 16'h0}; // RULE_06
      end
      if (flags_en) begin
        sel_flag_ff <= nxt_sel_flag; // RULE_08
        n_ff <= nxt_n;
        z_ff <= nxt_z;
        v_ff <= nxt_v;
        greater_ff <= nxt_greater;
      end
      if (bus_write && bus_addr == `OFS_CTRL) begin
        cs_ff <= bus_wdata[2:0];
        sat_ff <= bus_wdata[8];
      end
      bus_rdata <= 32'h0;
      if (bus_read) begin
        if (bus_addr == `OFS_CTRL) begin
          bus_rdata <= {23'h0, sat_ff, 5'h0, cs_ff};
        end else if (bus_addr == `OFS_FLAGS) begin
          bus_rdata <= {27'h0, greater_ff, z_ff, n_ff, v_ff, sel_flag_ff};
        end else if (bus_addr >= `OFS_REG_BASE) begin
          bus_rdata <= dsp_reg_ff[bus_addr[2:0]][31:0];
        end
      end
    end
  end

endmodule // dsp_int_logic_multiply_unit

// ### logic/dsp_int_logic_multiply_unit_defs.vh
// Constants for the DSP integer, logical and multiply unit
`ifndef DSP_INT_LOGIC_MULTIPLY_UNIT_DEFS_VH
`define DSP_INT_LOGIC_MULTIPLY_UNIT_DEFS_VH

// Operation codes
`define OP_NONE 3'h0
`define OP_INC 3'h1
`define OP_DEC 3'h2
`define OP_AND 3'h3
`define OP_OR 3'h4
`define OP_XOR 3'h5
`define OP_MUL 3'h6

// Register indexes
`define REG_ACC0 3'h0
`define REG_ACC1 3'h1
`define REG_MUL0 3'h2
`define REG_MUL1 3'h3
`define REG_XIN0 3'h4
`define REG_XIN1 3'h5
`define REG_YIN0 3'h6
`define REG_YIN1 3'h7

// Condition-select encodings
`define CS_CARRY 3'h0
`define CS_NEG 3'h1
`define CS_ZERO 3'h2
`define CS_OVF 3'h3
`define CS_GREATER 3'h4
`define CS_GE 3'h5

// Field layout of a 40-bit register
`define GUARD_MSB 39
`define GUARD_LSB 32
`define UPPER_MSB 31
`define UPPER_LSB 16
`define LOWER_MSB 15

// Multiply overflow and integer saturation constants
`define MUL_MIN_OPERAND 16'h8000
`define MUL_OVF_RESULT 32'h80000000
`define MUL_SAT_RESULT 32'h7FFFFFFF
`define INT_SAT_MAX 16'h7FFF
`define INT_SAT_MIN 16'h8000

// Register bus offsets (one word each)
`define OFS_CTRL 4'h0
`define OFS_FLAGS 4'h1
`define OFS_REG_BASE 4'h8

`endif

// ### verification/dsp_int_logic_multiply_unit_tb.sv
// Self-checking testbench for the DSP integer, logical and multiply unit
`timescale 1ns/1ns
`include "dsp_int_logic_multiply_unit_defs.vh"
`define CHK(nm, e, g) begin \
  total_checks = total_checks + 1; \
  if ((g) !== (e)) begin \
    n_fail = n_fail + 1; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); \
  end \
end
module dsp_int_logic_multiply_unit_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire op_valid, op_conditional, op_use_second, load_valid, bus_write, bus_read;
  wire [2:0] op_code, result_target_select, load_target, cond_select;
  wire [1:0] first_source_select, second_source_select;
  wire [1:0] mul_first_operand, mul_second_operand, mul_result_target;
  wire [15:0] load_word;
  wire [3:0] bus_addr;
  wire [31:0] bus_wdata, bus_rdata;
  wire saturate_enable, selectable_condition_flag, negative_flag, zero_flag;
  wire overflow_flag, greater_than_flag, op_illegal_ff;
  int n_fail = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  dsp_int_logic_multiply_unit u_dsp_int_logic_multiply_unit (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_conditional(op_conditional), .op_use_second(op_use_second),
    .first_source_select(first_source_select), .second_source_select(second_source_select),
    .result_target_select(result_target_select), .mul_first_operand(mul_first_operand),
    .mul_second_operand(mul_second_operand), .mul_result_target(mul_result_target),
    .load_valid(load_valid), .load_target(load_target), .load_word(load_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .cond_select(cond_select), .saturate_enable(saturate_enable),
    .selectable_condition_flag(selectable_condition_flag), .negative_flag(negative_flag),
    .zero_flag(zero_flag), .overflow_flag(overflow_flag),
    .greater_than_flag(greater_than_flag), .op_illegal_ff(op_illegal_ff));
  dsp_stage_model pipe (
    .clk(clk), .op_valid(op_valid), .op_code(op_code), .op_conditional(op_conditional),
    .op_use_second(op_use_second), .first_source_select(first_source_select),
    .second_source_select(second_source_select), .result_target_select(result_target_select),
    .mul_first_operand(mul_first_operand), .mul_second_operand(mul_second_operand),
    .mul_result_target(mul_result_target), .load_valid(load_valid),
    .load_target(load_target), .load_word(load_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata));
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    pipe.rd(a, d);
    `CHK("bus_rdata", e, d)
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus_map;
    rdchk(`OFS_CTRL, 32'h0);
    rdchk(4'h3, 32'h0);
    pipe.wr(`OFS_CTRL, 32'h105);
    `CHK("saturate_enable", 1'b1, saturate_enable)
    `CHK("cond_select", 3'h5, cond_select)
    pipe.wr(`OFS_CTRL, 32'h0);
  endtask
  task int_ops;
    pipe.ld(`REG_XIN0, 16'h8000);
    rdchk(`OFS_REG_BASE + `REG_XIN0, 32'h80000000);
    pipe.op(`OP_DEC, 1'b0, 1'b0, 2'h2, 2'h0, `REG_XIN1);
    rdchk(`OFS_REG_BASE + `REG_XIN1, 32'h7FFF0000);
    `CHK("negative_flag", 1'b1, negative_flag)
    `CHK("overflow_flag", 1'b1, overflow_flag)
    pipe.wr(`OFS_CTRL, 32'h100);
    pipe.op(`OP_DEC, 1'b0, 1'b0, 2'h2, 2'h0, `REG_XIN1);
    rdchk(`OFS_REG_BASE + `REG_XIN1, 32'h80000000);
    pipe.op(`OP_INC, 1'b1, 1'b0, 2'h3, 2'h0, `REG_XIN1);
    rdchk(`OFS_REG_BASE + `REG_XIN1, 32'h80010000);
    pipe.wr(`OFS_CTRL, 32'h3);
    pipe.op(`OP_INC, 1'b0, 1'b0, 2'h3, 2'h0, `REG_YIN1);
  endtask
  task mul_ops;
    pipe.wr(`OFS_CTRL, 32'h0);
    pipe.ld(`REG_XIN0, 16'h1234);
    pipe.ld(`REG_YIN0, 16'h0003);
    pipe.mul(2'h1, 2'h2, 2'h2);
    rdchk(`OFS_REG_BASE + `REG_MUL0, 32'h00006D38);
    pipe.op(`OP_INC, 1'b0, 1'b1, 2'h0, 2'h2, `REG_MUL1);
    rdchk(`OFS_REG_BASE + `REG_MUL1, 32'h00010000);
    pipe.ld(`REG_XIN0, 16'hFFFF);
    pipe.mul(2'h1, 2'h2, 2'h1);
    rdchk(`OFS_REG_BASE + `REG_ACC1, 32'hFFFFFFFA);
    // Guard of all ones makes the increment wrap to zero
    pipe.op(`OP_INC, 1'b0, 1'b0, 2'h1, 2'h0, `REG_MUL1);
    `CHK("zero_flag", 1'b1, zero_flag)
    pipe.ld(`REG_XIN0, 16'h8000);
    pipe.ld(`REG_YIN0, 16'h8000);
    pipe.mul(2'h1, 2'h2, 2'h1);
    rdchk(`OFS_REG_BASE + `REG_ACC1, 32'h80000000);
    // Guard of zero keeps the increment positive
    pipe.op(`OP_INC, 1'b0, 1'b0, 2'h1, 2'h0, `REG_MUL1);
    `CHK("negative_flag", 1'b0, negative_flag)
    `CHK("greater_than_flag", 1'b1, greater_than_flag)
    pipe.wr(`OFS_CTRL, 32'h100);
    pipe.mul(2'h1, 2'h2, 2'h0);
    rdchk(`OFS_REG_BASE + `REG_ACC0, 32'h7FFFFFFF);
  endtask
  task logic_ops;
    int cs;
    pipe.ld(`REG_XIN0, 16'hF00F);
    pipe.ld(`REG_YIN0, 16'h9001);
    for (cs = 0; cs < 8; cs++) begin
      pipe.wr(`OFS_CTRL, 32'(cs));
      pipe.op(`OP_AND, 1'b0, 1'b0, 2'h2, 2'h0, `REG_ACC0);
      `CHK("selectable_condition_flag", cs == 1, selectable_condition_flag)
    end
    rdchk(`OFS_REG_BASE + `REG_ACC0, 32'h90010000);
    `CHK("negative_flag", 1'b1, negative_flag)
    pipe.op(`OP_OR, 1'b0, 1'b0, 2'h2, 2'h0, `REG_MUL1);
    rdchk(`OFS_REG_BASE + `REG_MUL1, 32'hF00F0000);
    pipe.ld(`REG_YIN0, 16'hF00F);
    pipe.wr(`OFS_CTRL, 32'h2);
    pipe.op(`OP_XOR, 1'b0, 1'b0, 2'h2, 2'h0, `REG_YIN1);
    `CHK("selectable_condition_flag", 1'b1, selectable_condition_flag)
    rdchk(`OFS_REG_BASE + `REG_YIN1, 32'h0);
    // Nonzero result of a conditional op must not touch the flags
    pipe.op(`OP_AND, 1'b1, 1'b0, 2'h2, 2'h0, `REG_XIN1);
    `CHK("zero_flag", 1'b1, zero_flag)
    `CHK("selectable_condition_flag", 1'b1, selectable_condition_flag)
    rdchk(`OFS_REG_BASE + `REG_XIN1, 32'hF00F0000);
    pipe.op(3'h7, 1'b0, 1'b0, 2'h0, 2'h0, `REG_ACC0);
    `CHK("op_illegal_ff", 1'b1, op_illegal_ff)
    rdchk(`OFS_REG_BASE + `REG_ACC0, 32'h90010000);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus_map;
    int_ops;
    mul_ops;
    logic_ops;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule // dsp_int_logic_multiply_unit_tb

// ### verification/dsp_stage_model.sv
// Pipeline stage and register-port master that drives the unit
`timescale 1ns/1ns
`include "dsp_int_logic_multiply_unit_defs.vh"
module dsp_stage_model (
  input wire logic clk,
  output logic op_valid,
  output logic [2:0] op_code,
  output logic op_conditional,
  output logic op_use_second,
  output logic [1:0] first_source_select,
  output logic [1:0] second_source_select,
  output logic [2:0] result_target_select,
  output logic [1:0] mul_first_operand,
  output logic [1:0] mul_second_operand,
  output logic [1:0] mul_result_target,
  output logic load_valid,
  output logic [2:0] load_target,
  output logic [15:0] load_word,
  output logic [3:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic bus_write,
  output logic bus_read,
  input wire logic [31:0] bus_rdata
);
  initial begin
    {op_valid, op_code, op_conditional, op_use_second, first_source_select,
      second_source_select, result_target_select, mul_first_operand, mul_second_operand,
      mul_result_target, load_valid, load_target, load_word, bus_addr, bus_wdata,
      bus_write, bus_read} = '0;
  end
  task op(input logic [2:0] c, input logic cond, sec, input logic [1:0] fs, ss,
    input logic [2:0] dz);
    op_code <= c;
    op_conditional <= cond;
    op_use_second <= sec;
    first_source_select <= fs;
    second_source_select <= ss;
    result_target_select <= dz;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
  endtask
  task mul(input logic [1:0] e, f, g);
    mul_first_operand <= e;
    mul_second_operand <= f;
    mul_result_target <= g;
    op(`OP_MUL, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0);
  endtask
  task ld(input logic [2:0] t, input logic [15:0] w);
    load_target <= t;
    load_word <= w;
    load_valid <= 1'b1;
    @(posedge clk);
    load_valid <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk);
    bus_read <= 1'b0;
    @(posedge clk);
    d = bus_rdata;
  endtask
endmodule // dsp_stage_model

// ### verification/dsp_unit_properties.sv
// Flag checks for the DSP integer, logical and multiply unit
`timescale 1ns/1ns
`include "dsp_int_logic_multiply_unit_defs.vh"
module dsp_unit_properties (
  input wire clk,
  input wire rst,
  input wire op_valid,
  input wire [2:0] op_code,
  input wire op_conditional,
  input wire [2:0] cond_select,
  input wire selectable_condition_flag,
  input wire negative_flag,
  input wire zero_flag,
  input wire overflow_flag,
  input wire greater_than_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [4:0] flags = {greater_than_flag, zero_flag, overflow_flag, negative_flag,
    selectable_condition_flag};
  sequence alu_issue;
    op_valid && op_code >= `OP_INC && op_code <= `OP_XOR;
  endsequence
  sequence upd_issue;
    alu_issue ##0 !op_conditional;
  endsequence
  sequence logic_issue;
    upd_issue ##0 op_code >= `OP_AND;
  endsequence
  a_mul_flags_kept: assert property (op_valid && op_code == `OP_MUL |=> $stable(flags))
    else $error("flags changed by multiply");
  a_cond_flags_kept: assert property (alu_issue ##0 op_conditional |=> $stable(flags))
    else $error("flags changed by conditional op");
  a_logic_dc_clear: assert property (logic_issue ##0 (cond_select inside {3'h0, 3'h3, 3'h4,
    3'h5}) |=> !selectable_condition_flag) else $error("logic flag not cleared");
  a_logic_v_gt: assert property (logic_issue |=> !overflow_flag && !greater_than_flag)
    else $error("logic overflow or greater flag set");
  a_neg_mode_dc: assert property (upd_issue ##0 cond_select == `CS_NEG |=>
    selectable_condition_flag == negative_flag) else $error("negative mode mismatch");
  a_zero_mode_dc: assert property (upd_issue ##0 cond_select == `CS_ZERO |=>
    selectable_condition_flag == zero_flag) else $error("zero mode mismatch");
  a_ovf_mode_dc: assert property (upd_issue ##0 cond_select == `CS_OVF |=>
    selectable_condition_flag == overflow_flag) else $error("overflow mode mismatch");
  a_rsvd_cs_clear: assert property (upd_issue ##0 cond_select[2:1] == 2'b11 |=>
    !selectable_condition_flag) else $error("reserved mode flag set");
endmodule // dsp_unit_properties
bind dsp_int_logic_multiply_unit dsp_unit_properties u_chk (.clk, .rst, .op_valid, .op_code,
  .op_conditional, .cond_select, .selectable_condition_flag, .negative_flag, .zero_flag,
  .overflow_flag, .greater_than_flag);
